// File: rcrb_bank.sv
// Remote channel register bank: limits, corrections, result mirror, write protect and identity.
// Assumes a bus front end on clk_sys that issues one pointer load, word write or word read
// at a time, and measurement inputs that are already synchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module rcrb_bank #(
  parameter logic [15:0] MAKER_ID = rcrb_pkg::MAKER_ID_DEFAULT,
  parameter logic [15:0] PART_ID = rcrb_pkg::PART_ID_DEFAULT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Pointer and word transfers from the bus front end
  input wire logic ptr_load,
  input wire logic [rcrb_pkg::PTR_W-1:0] ptr_value,
  input wire logic wr_stb,
  input wire logic [rcrb_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_stb,
  output logic [rcrb_pkg::PTR_W-1:0] register_pointer,
  output logic wr_ack,
  output logic wr_nack,
  output logic rd_valid,
  output logic [rcrb_pkg::DATA_W-1:0] rd_data,
  // Measurements and hysteresis from the conversion side
  input wire logic [rcrb_pkg::TEMP_W-1:0] local_result_field,
  input wire logic [rcrb_pkg::NUM_REMOTE-1:0][rcrb_pkg::TEMP_W-1:0] remote_result_field,
  input wire logic [rcrb_pkg::DATA_W-1:0] hysteresis_word,
  // State toward the conversion side
  output logic [rcrb_pkg::NUM_REMOTE-1:0] primary_overtemp,
  output logic [rcrb_pkg::NUM_REMOTE-1:0] secondary_overtemp,
  output logic lock_engaged,
  output logic [rcrb_pkg::NUM_CORR-1:0][rcrb_pkg::DATA_W-1:0] offset_field,
  output logic [rcrb_pkg::NUM_CORR-1:0][rcrb_pkg::DATA_W-1:0] ideality_field
);
  import rcrb_pkg::*;

  // Pointer decode, shared by the write and read paths.
  function automatic rcrb_decode_t decode(input logic [7:0] p);
    rcrb_decode_t d;
    d.kind = RCRB_K_NONE;
    d.idx = 3'd0;
    if (p == ADDR_R1_PRIMARY) begin
      d = '{RCRB_K_PRIMARY, 3'd0};
    end else if (p == ADDR_R1_SECONDARY) begin
      d = '{RCRB_K_SECONDARY, 3'd0};
    end else if (p == ADDR_R2_OFFSET) begin
      d = '{RCRB_K_OFFSET, 3'd0};
    end else if (p == ADDR_R2_IDEALITY) begin
      d = '{RCRB_K_IDEALITY, 3'd0};
    end else if (p == ADDR_R2_PRIMARY) begin
      d = '{RCRB_K_PRIMARY, 3'd1};
    end else if (p == ADDR_R2_SECONDARY) begin
      d = '{RCRB_K_SECONDARY, 3'd1};
    end else if (p == ADDR_R3_OFFSET) begin
      d = '{RCRB_K_OFFSET, 3'd1};
    end else if (p == ADDR_R3_IDEALITY) begin
      d = '{RCRB_K_IDEALITY, 3'd1};
    end else if (p == ADDR_R3_PRIMARY) begin
      d = '{RCRB_K_PRIMARY, 3'd2};
    end else if (p == ADDR_R3_SECONDARY) begin
      d = '{RCRB_K_SECONDARY, 3'd2};
    end else if (p == ADDR_R4_OFFSET) begin
      d = '{RCRB_K_OFFSET, 3'd2};
    end else if (p == ADDR_R4_IDEALITY) begin
      d = '{RCRB_K_IDEALITY, 3'd2};
    end else if (p == ADDR_R4_PRIMARY) begin
      d = '{RCRB_K_PRIMARY, 3'd3};
    end else if (p == ADDR_R4_SECONDARY) begin
      d = '{RCRB_K_SECONDARY, 3'd3};
    end else if (p >= ADDR_LOCAL_BURST && p <= ADDR_R4_BURST) begin
      d = '{RCRB_K_BURST, 3'(p - ADDR_LOCAL_BURST)};
    end else if (p == ADDR_WRITE_PROTECT) begin
      d = '{RCRB_K_PROTECT, 3'd0};
    end else if (p == ADDR_MAKER_ID) begin
      d = '{RCRB_K_MAKER, 3'd0};
    end else if (p == ADDR_PART_ID) begin
      d = '{RCRB_K_PART, 3'd0};
    end
    // Pointer values outside the map decode to no kind and fall to the default arms.
    return d;
  endfunction

  // Comparator with hysteresis; words are compared as signed two's complement.
  // The release threshold is taken one bit wider so a low limit cannot wrap.
  function automatic logic over_limit(input logic cur, input logic [15:0] temp,
                                      input logic [15:0] lim, input logic [15:0] hyst);
    logic signed [16:0] t;
    logic signed [16:0] l;
    logic signed [16:0] release_at;
    t = {temp[15], temp};
    l = {lim[15], lim};
    release_at = l - $signed({1'b0, hyst});
    if (t > l) begin
      return 1'b1;
    end else if (t <= release_at) begin
      return 1'b0;
    end
    // Between the two thresholds the flag keeps its last value.
    return cur;
  endfunction

  function automatic logic [15:0] result_word(input logic [TEMP_W-1:0] r);
    return {r, {TEMP_LSB{1'b0}}};
  endfunction

  logic [NUM_REMOTE-1:0][15:0] primary_limit;
  logic [NUM_REMOTE-1:0][15:0] secondary_limit;
  logic [NUM_REMOTE-1:0][15:0] next_primary_limit;
  logic [NUM_REMOTE-1:0][15:0] next_secondary_limit;
  logic [NUM_CORR-1:0][15:0] next_offset_field;
  logic [NUM_CORR-1:0][15:0] next_ideality_field;
  logic next_lock_engaged;
  logic [7:0] next_register_pointer;
  logic next_wr_ack;
  logic next_wr_nack;
  logic next_rd_valid;
  logic [15:0] next_rd_data;
  logic [NUM_REMOTE-1:0] next_primary_overtemp;
  logic [NUM_REMOTE-1:0] next_secondary_overtemp;
  rcrb_decode_t cur_dec;
  logic lockable;

  assign cur_dec = decode(register_pointer);
  // Only limit and correction words are refused under lock; the lock word itself stays
  // writable, otherwise the bank could never be unlocked again.
  assign lockable = (cur_dec.kind == RCRB_K_PRIMARY) || (cur_dec.kind == RCRB_K_SECONDARY) ||
                    (cur_dec.kind == RCRB_K_OFFSET) || (cur_dec.kind == RCRB_K_IDEALITY);

  // Register writes and the write-protect state.
  always_comb begin
    next_primary_limit = primary_limit;
    next_secondary_limit = secondary_limit;
    next_offset_field = offset_field;
    next_ideality_field = ideality_field;
    next_lock_engaged = lock_engaged;
    next_wr_ack = 1'b0;
    next_wr_nack = 1'b0;
    // A write never moves the pointer, so a read-back after it needs no new load.
    if (wr_stb) begin
      if (lock_engaged && lockable) begin
        next_wr_nack = 1'b1;
      end else begin
        next_wr_ack = 1'b1;
        case (cur_dec.kind)
          RCRB_K_PRIMARY: begin
            next_primary_limit[cur_dec.idx[1:0]] = wr_data & LIMIT_MASK;
          end
          RCRB_K_SECONDARY: begin
            next_secondary_limit[cur_dec.idx[1:0]] = wr_data & LIMIT_MASK;
          end
          RCRB_K_OFFSET: begin
            next_offset_field[cur_dec.idx[1:0]] = wr_data & OFFSET_MASK;
            next_offset_field[cur_dec.idx[1:0]][OFS_TOP_BIT] = wr_data[OFS_SIGN_BIT];
          end
          RCRB_K_IDEALITY: begin
            next_ideality_field[cur_dec.idx[1:0]] = wr_data & IDEALITY_MASK;
          end
          RCRB_K_PROTECT: begin
            // Any value other than the two keys leaves the lock as it is.
            if (wr_data == KEY_LOCK) begin
              next_lock_engaged = 1'b1;
            end else if (wr_data == KEY_UNLOCK) begin
              next_lock_engaged = 1'b0;
            end
          end
          default: begin
            // Results, identity words and unassigned pointers take no data.
            next_lock_engaged = lock_engaged;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REMOTE; i++) begin
        primary_limit[i] <= PRIMARY_RESET;
        secondary_limit[i] <= SECONDARY_RESET;
      end
      for (int i = 0; i < NUM_CORR; i++) begin
        offset_field[i] <= CORR_RESET;
        ideality_field[i] <= CORR_RESET;
      end
      // Coming up locked means no limit or correction word can change before the host has unlocked.
      lock_engaged <= 1'b1;
      wr_ack <= 1'b0;
      wr_nack <= 1'b0;
    end else begin
      primary_limit <= next_primary_limit;
      secondary_limit <= next_secondary_limit;
      offset_field <= next_offset_field;
      ideality_field <= next_ideality_field;
      lock_engaged <= next_lock_engaged;
      wr_ack <= next_wr_ack;
      wr_nack <= next_wr_nack;
    end
  end

  // Pointer and read path.
  always_comb begin
    next_register_pointer = register_pointer;
    next_rd_valid = 1'b0;
    next_rd_data = rd_data;
    // A pointer load wins over a read strobe, so a fresh address is never read stale.
    if (ptr_load) begin
      next_register_pointer = ptr_value;
    end else if (rd_stb) begin
      next_rd_valid = 1'b1;
      case (cur_dec.kind)
        RCRB_K_PRIMARY: begin
          next_rd_data = primary_limit[cur_dec.idx[1:0]];
        end
        RCRB_K_SECONDARY: begin
          next_rd_data = secondary_limit[cur_dec.idx[1:0]];
        end
        RCRB_K_OFFSET: begin
          next_rd_data = offset_field[cur_dec.idx[1:0]];
        end
        RCRB_K_IDEALITY: begin
          next_rd_data = ideality_field[cur_dec.idx[1:0]];
        end
        RCRB_K_BURST: begin
          if (cur_dec.idx == 3'd0) begin
            next_rd_data = result_word(local_result_field);
          end else begin
            // Slots 1 to 4 hold remotes 1 to 4; the two-bit subtraction wraps slot 4
            // onto the last remote entry.
            next_rd_data = result_word(remote_result_field[cur_dec.idx[1:0] - 2'd1]);
          end
          // The pointer walks the block-read range and parks on its last word.
          if (register_pointer != ADDR_R4_BURST) begin
            next_register_pointer = register_pointer + 8'h01;
          end
        end
        RCRB_K_PROTECT: begin
          next_rd_data = lock_engaged ? LOCKED_READBACK : UNLOCKED_READBACK;
        end
        RCRB_K_MAKER: begin
          next_rd_data = MAKER_ID;
        end
        RCRB_K_PART: begin
          next_rd_data = PART_ID;
        end
        default: begin
          next_rd_data = ZERO_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      register_pointer <= PTR_RESET;
      rd_valid <= 1'b0;
      rd_data <= ZERO_WORD;
    end else begin
      register_pointer <= next_register_pointer;
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
    end
  end

  // Over-limit flags per remote channel.
  // Both levels share the one hysteresis word, so their release points move together.
  always_comb begin
    for (int i = 0; i < NUM_REMOTE; i++) begin
      next_primary_overtemp[i] = over_limit(primary_overtemp[i],
        result_word(remote_result_field[i]), primary_limit[i], hysteresis_word);
      next_secondary_overtemp[i] = over_limit(secondary_overtemp[i],
        result_word(remote_result_field[i]), secondary_limit[i], hysteresis_word);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      primary_overtemp <= '0;
      secondary_overtemp <= '0;
    end else begin
      primary_overtemp <= next_primary_overtemp;
      secondary_overtemp <= next_secondary_overtemp;
    end
  end

endmodule // rcrb_bank

`default_nettype wire

// File: rcrb_bank_chk.sv
// Concurrent checks on the ports of the remote channel register bank.
// Assumes every strobe is answered one clock later and that the bind sees the bank's ports.
`timescale 1ns/10ps
`default_nettype none
module rcrb_bank_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Host side
  input wire logic ptr_load,
  input wire logic [rcrb_pkg::PTR_W-1:0] ptr_value,
  input wire logic wr_stb,
  input wire logic [rcrb_pkg::DATA_W-1:0] wr_data,
  input wire logic rd_stb,
  input wire logic [rcrb_pkg::PTR_W-1:0] register_pointer,
  input wire logic wr_ack,
  input wire logic wr_nack,
  input wire logic rd_valid,
  input wire logic [rcrb_pkg::DATA_W-1:0] rd_data,
  input wire logic lock_engaged
);
  import rcrb_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_wr_answer; wr_stb |=> (wr_ack ^ wr_nack); endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered once");
  property p_no_nack; wr_stb && !lock_engaged |=> !wr_nack; endproperty
  a_no_nack: assert property (p_no_nack) else $error("write refused while unlocked");
  property p_lock; wr_stb && register_pointer == ADDR_WRITE_PROTECT && wr_data == KEY_LOCK
    |=> lock_engaged && wr_ack; endproperty
  a_lock: assert property (p_lock) else $error("lock key ignored");
  property p_unlock; wr_stb && register_pointer == ADDR_WRITE_PROTECT && wr_data == KEY_UNLOCK
    |=> !lock_engaged; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock key ignored");
  property p_lock_hold; !(wr_stb && register_pointer == ADDR_WRITE_PROTECT)
    |=> $stable(lock_engaged); endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock changed without key");
  property p_read; rd_stb && !ptr_load |=> rd_valid; endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_ptr; ptr_load |=> register_pointer == $past(ptr_value); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load lost");
  property p_burst; rd_stb && !ptr_load && register_pointer inside {[8'h80:8'h83]}
    |=> register_pointer == $past(register_pointer) + 8'h01; endproperty
  a_burst: assert property (p_burst) else $error("burst pointer did not advance");
  property p_res_low; rd_stb && !ptr_load && register_pointer inside {[8'h81:8'h84]}
    |=> rd_data[2:0] == 3'b000; endproperty
  a_res_low: assert property (p_res_low) else $error("result low bits not zero");
  property p_lock_read; rd_stb && !ptr_load && register_pointer == ADDR_WRITE_PROTECT
    |=> rd_data == ($past(lock_engaged) ? LOCKED_READBACK : UNLOCKED_READBACK); endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read-back wrong");
  property p_reset_lock; $rose(rst_b) |-> lock_engaged; endproperty
  a_reset_lock: assert property (p_reset_lock) else $error("not locked after reset");
endmodule // rcrb_bank_chk

bind rcrb_bank rcrb_bank_chk u_chk (.clk_sys, .rst_b, .ptr_load, .ptr_value, .wr_stb, .wr_data,
  .rd_stb, .register_pointer, .wr_ack, .wr_nack, .rd_valid, .rd_data, .lock_engaged);
`default_nettype wire

// File: rcrb_host.sv
// Host controller model: loads the pointer (reads may skip the load), then moves one whole word per request.
// Assumes the bank answers each strobe exactly one clock later.
`timescale 1ns/10ps
`default_nettype none
module rcrb_host (
  // Clock
  input wire logic clk_sys,
  // Requests toward the bank
  output logic ptr_load,
  output logic [rcrb_pkg::PTR_W-1:0] ptr_value,
  output logic wr_stb,
  output logic [rcrb_pkg::DATA_W-1:0] wr_data,
  output logic rd_stb,
  // Answers from the bank
  input wire logic wr_ack,
  input wire logic wr_nack,
  input wire logic rd_valid,
  input wire logic [rcrb_pkg::DATA_W-1:0] rd_data
);
  import rcrb_pkg::*;
  initial begin
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    wr_stb = 1'b0;
    wr_data = 16'h0000;
    rd_stb = 1'b0;
  end
  // Idle qualifiers show the inverse, so a bank that samples them late sees garbage.
  task automatic load(input logic [7:0] a);
    @(posedge clk_sys);
    ptr_load <= 1'b1;
    ptr_value <= a;
    @(posedge clk_sys);
    ptr_load <= 1'b0;
    ptr_value <= ~a;
  endtask
  // Callers send the lock key once setup writes are done.
  task automatic write(input logic [7:0] a, input logic [15:0] d, output logic [1:0] resp);
    load(a);
    wr_stb <= 1'b1;
    wr_data <= d;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    wr_data <= ~d;
    @(posedge clk_sys);
    resp = {wr_ack, wr_nack};
  endtask
  task automatic read(input logic ld, input logic [7:0] a, output logic [15:0] d);
    if (ld) begin
      load(a);
    end
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(posedge clk_sys);
    d = rd_valid ? rd_data : 16'hxxxx;
  endtask
endmodule // rcrb_host
`default_nettype wire

// File: rcrb_pkg.sv
// Constants, register map and decode types for the remote channel register bank.
// Assumes a framing front end that turns bus traffic into pointer loads and word transfers.
package rcrb_pkg;

  localparam int PTR_W = 8;
  localparam int DATA_W = 16;
  localparam int TEMP_W = 13;
  localparam int NUM_REMOTE = 4;
  localparam int NUM_CORR = 3;
  localparam int TEMP_LSB = 3;
  localparam int OFS_SIGN_BIT = 14;
  localparam int OFS_TOP_BIT = 15;

  // Pointer values.
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] ADDR_R1_PRIMARY = 8'h42;
  localparam logic [7:0] ADDR_R1_SECONDARY = 8'h43;
  localparam logic [7:0] ADDR_R2_OFFSET = 8'h48;
  localparam logic [7:0] ADDR_R2_IDEALITY = 8'h49;
  localparam logic [7:0] ADDR_R2_PRIMARY = 8'h4a;
  localparam logic [7:0] ADDR_R2_SECONDARY = 8'h4b;
  localparam logic [7:0] ADDR_R3_OFFSET = 8'h50;
  localparam logic [7:0] ADDR_R3_IDEALITY = 8'h51;
  localparam logic [7:0] ADDR_R3_PRIMARY = 8'h52;
  localparam logic [7:0] ADDR_R3_SECONDARY = 8'h53;
  localparam logic [7:0] ADDR_R4_OFFSET = 8'h58;
  localparam logic [7:0] ADDR_R4_IDEALITY = 8'h59;
  localparam logic [7:0] ADDR_R4_PRIMARY = 8'h5a;
  localparam logic [7:0] ADDR_R4_SECONDARY = 8'h5b;
  localparam logic [7:0] ADDR_LOCAL_BURST = 8'h80;
  localparam logic [7:0] ADDR_R1_BURST = 8'h81;
  localparam logic [7:0] ADDR_R2_BURST = 8'h82;
  localparam logic [7:0] ADDR_R3_BURST = 8'h83;
  localparam logic [7:0] ADDR_R4_BURST = 8'h84;
  localparam logic [7:0] ADDR_WRITE_PROTECT = 8'hc4;
  localparam logic [7:0] ADDR_MAKER_ID = 8'hfe;
  localparam logic [7:0] ADDR_PART_ID = 8'hff;

  // Reset values and field masks.
  localparam logic [15:0] PRIMARY_RESET = 16'h3e80;
  localparam logic [15:0] SECONDARY_RESET = 16'h7fc0;
  localparam logic [15:0] CORR_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_MASK = 16'hffc0;
  localparam logic [15:0] OFFSET_MASK = 16'h7ff8;
  localparam logic [15:0] IDEALITY_MASK = 16'hff00;
  localparam logic [15:0] ZERO_WORD = 16'h0000;

  // Write-protect keys and read-back values.
  localparam logic [15:0] KEY_LOCK = 16'h5ca6;
  localparam logic [15:0] KEY_UNLOCK = 16'heb19;
  localparam logic [15:0] LOCKED_READBACK = 16'h8000;
  localparam logic [15:0] UNLOCKED_READBACK = 16'h0000;

  // Arbitrary neutral identity values.
  localparam logic [15:0] MAKER_ID_DEFAULT = 16'h0a5a;
  localparam logic [15:0] PART_ID_DEFAULT = 16'h0102;

  typedef enum logic [3:0] {
    RCRB_K_NONE,
    RCRB_K_PRIMARY,
    RCRB_K_SECONDARY,
    RCRB_K_OFFSET,
    RCRB_K_IDEALITY,
    RCRB_K_BURST,
    RCRB_K_PROTECT,
    RCRB_K_MAKER,
    RCRB_K_PART
  } rcrb_kind_t;

  typedef struct packed {
    rcrb_kind_t kind;
    logic [2:0] idx;
  } rcrb_decode_t;

endpackage

// File: rcrb_tb.sv
// Self-checking bench for the remote channel register bank.
// Assumes rcrb_host makes every bus request; results and hysteresis are driven here.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rcrb_pkg::*;
  logic clk_sys, rst_b, ptr_load, wr_stb, rd_stb, wr_ack, wr_nack, rd_valid, lock_engaged;
  logic [7:0] ptr_value, register_pointer;
  logic [15:0] wr_data, rd_data, hysteresis_word, rd_word;
  logic [12:0] local_result_field;
  logic [3:0][12:0] remote_result_field;
  logic [3:0] primary_overtemp, secondary_overtemp;
  logic [2:0][15:0] offset_field, ideality_field;
  logic [1:0] resp;
  int fail_count, comparisons;
  logic [7:0] lim_addr [4] = '{8'h42, 8'h4a, 8'h52, 8'h5a};
  logic [7:0] corr_addr [3] = '{8'h48, 8'h50, 8'h58};
  logic [15:0] burst_exp [5] = '{16'h1000, 16'h55e0, 16'h0008, 16'hffc0, 16'hffc0};
  rcrb_bank DUT (.clk_sys, .rst_b, .ptr_load, .ptr_value, .wr_stb, .wr_data, .rd_stb,
    .register_pointer, .wr_ack, .wr_nack, .rd_valid, .rd_data, .local_result_field,
    .remote_result_field, .hysteresis_word, .primary_overtemp, .secondary_overtemp,
    .lock_engaged, .offset_field, .ideality_field);
  rcrb_host u_host (.clk_sys, .ptr_load, .ptr_value, .wr_stb, .wr_data, .rd_stb, .wr_ack,
    .wr_nack, .rd_valid, .rd_data);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    u_host.read(1'b1, a, rd_word);
    chk(rd_word, e);
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
    u_host.write(a, d, resp);
    chk({14'h0000, resp}, {14'h0000, e});
  endtask
  // Flags are registered, so a new temperature shows one clock after it is sampled.
  task flag(input logic [12:0] t, input logic e);
    remote_result_field[0] <= t;
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, primary_overtemp[0]}, {15'h0000, e});
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk_sys);
    fail_count++;
    results();
  end
  initial begin
    rst_b = 1'b0;
    hysteresis_word = 16'h0100;
    local_result_field = 13'h0123;
    remote_result_field = {13'h1ff8, 13'h0001, 13'h0abc, 13'h0000};
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(8'hc4, 16'h8000);
    for (int i = 0; i < 4; i++) begin
      rd(lim_addr[i], 16'h3e80);
      rd(lim_addr[i] + 8'h01, 16'h7fc0);
    end
    for (int i = 0; i < 3; i++) begin
      rd(corr_addr[i], 16'h0000);
      rd(corr_addr[i] + 8'h01, 16'h0000);
    end
    wr(8'h42, 16'h1000, 2'b01);
    rd(8'h42, 16'h3e80);
    wr(8'hc4, 16'heb19, 2'b10);
    rd(8'hc4, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      wr(lim_addr[i] + 8'h01, 16'hffff, 2'b10);
      rd(lim_addr[i] + 8'h01, 16'hffc0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(corr_addr[i], 16'h4007, 2'b10);
      rd(corr_addr[i], 16'hc000);
      wr(corr_addr[i] + 8'h01, 16'hffff, 2'b10);
      rd(corr_addr[i] + 8'h01, 16'hff00);
    end
    wr(8'h42, 16'h103f, 2'b10);
    rd(8'h42, 16'h1000);
    flag(13'h0201, 1'b1);
    flag(13'h01f0, 1'b1);
    flag(13'h01e0, 1'b0);
    flag(13'h0200, 1'b0);
    wr(8'hfe, 16'h0000, 2'b10);
    rd(8'hfe, MAKER_ID_DEFAULT);
    rd(8'hff, PART_ID_DEFAULT);
    wr(8'h10, 16'hffff, 2'b10);
    rd(8'h10, 16'h0000);
    wr(8'hc4, 16'h5ca6, 2'b10);
    rd(8'hc4, 16'h8000);
    wr(8'h49, 16'h1234, 2'b01);
    rd(8'h49, 16'hff00);
    wr(8'h81, 16'h5555, 2'b10);
    rd(8'h80, 16'h0918);
    for (int i = 0; i < 5; i++) begin
      u_host.read(1'b0, 8'h00, rd_word);
      chk(rd_word, burst_exp[i]);
    end
    chk({8'h00, register_pointer}, 16'h0084);
    chk(offset_field[2], 16'hc000);
    chk(ideality_field[0], 16'hff00);
    chk({12'h000, primary_overtemp}, 16'h0002);
    chk({12'h000, secondary_overtemp}, 16'h0007);
    // A second reset in mid-run must bring back the lock and the reset limits.
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(8'hc4, 16'h8000);
    rd(8'h42, 16'h3e80);
    results();
  end
endmodule // testbench
`default_nettype wire
